//--- src/opt_pkg.sv
// opt_pkg: register map, field positions and constants of the one-shot / pwm timer
package opt_pkg;
  // ***************************************************************************
  // bus and widths
  // ***************************************************************************
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;
  localparam int CNT_W = 16;
  localparam int HALF_W = 8;
  // ***************************************************************************
  // register offsets
  // ***************************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OSTART = 8'h04;
  localparam logic [7:0] ADDR_TIMER = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  // ***************************************************************************
  // control fields
  // ***************************************************************************
  localparam int CTRL_W = 9;
  localparam logic [8:0] CTRL_RST = 9'h000;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_MODE_BIT = 1;
  localparam int CTRL_PWM8_BIT = 2;
  localparam int CTRL_CLK_LSB = 3;
  localparam int CTRL_TRIG_PIN_BIT = 5;
  localparam int CTRL_TRIG_OVF_BIT = 6;
  localparam int CTRL_PULSE_OUT_BIT = 7;
  localparam int CTRL_GPIO_OUT_BIT = 8;
  localparam int OSTART_BIT = 0;
  // status fields
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_OUT_BIT = 1;
  localparam int STAT_PIN_BIT = 2;
  localparam int STAT_WAIT_BIT = 3;
  localparam int STAT_W = 4;
  // ***************************************************************************
  // count sources
  // ***************************************************************************
  localparam logic [1:0] CLK_F1 = 2'h0;
  localparam logic [1:0] CLK_F8 = 2'h1;
  localparam logic [1:0] CLK_F32 = 2'h2;
  localparam logic [1:0] CLK_SUBCLOCK_DIV32 = 2'h3;
  localparam int DIV_MAIN_A = 8;
  localparam int DIV_MAIN_B = 32;
  localparam int DIV_SUB = 32;
  // ***************************************************************************
  // interrupts and counter constants
  // ***************************************************************************
  localparam int IRQ_W = 2;
  localparam int IRQ_OS_BIT = 0;
  localparam int IRQ_PWM_BIT = 1;
  localparam logic [15:0] PWM16_LAST = 16'hFFFE;
  localparam logic [15:0] PWM8_LAST = 16'h00FE;
  localparam logic [15:0] TIMER_READ_VALUE = 16'h0000;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [7:0] PRE_ZERO = 8'h00;
  typedef enum logic [1:0] {ST_STOP, ST_WAIT, ST_RUN} opt_state_type;
endpackage

//--- src/opt_prescaler.sv
// opt_prescaler: divides the main clock and the subclock into four count-source ticks
`timescale 1ns/1ps
`default_nettype none
module opt_prescaler #(
  parameter int DIV_A = opt_pkg::DIV_MAIN_A,
  parameter int DIV_B = opt_pkg::DIV_MAIN_B,
  parameter int DIV_S = opt_pkg::DIV_SUB
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // selection
  input wire logic [1:0] clk_sel_in,
  input wire logic subclock_in,
  // tick
  output logic tick_out
);
  localparam int AW = $clog2(DIV_A);
  localparam int BW = $clog2(DIV_B);
  localparam int SW = $clog2(DIV_S);
  if (DIV_A < 2 || DIV_B < 2 || DIV_S < 2) begin : g_bad_div
    $error("opt_prescaler: divide ratios must be at least 2");
  end
  logic [AW-1:0] cnt_a_r;
  logic [BW-1:0] cnt_b_r;
  logic [SW-1:0] cnt_s_r;
  logic sub_q_r;
  logic tick_r;
  wire logic wrap_a = cnt_a_r == AW'(DIV_A - 1);
  wire logic wrap_b = cnt_b_r == BW'(DIV_B - 1);
  wire logic sub_rise = subclock_in & ~sub_q_r;
  wire logic wrap_s = sub_rise & (cnt_s_r == SW'(DIV_S - 1));
  wire logic tick_sel = (clk_sel_in == opt_pkg::CLK_F1) ? 1'b1 :
                        (clk_sel_in == opt_pkg::CLK_F8) ? wrap_a :
                        (clk_sel_in == opt_pkg::CLK_F32) ? wrap_b : wrap_s;
  // ***************************************************************************
  // free-running dividers, so a source change never waits on a stale count
  // ***************************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      cnt_a_r <= '0;
      cnt_b_r <= '0;
      cnt_s_r <= '0;
      sub_q_r <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      cnt_a_r <= wrap_a ? '0 : AW'(cnt_a_r + 1'b1);
      cnt_b_r <= wrap_b ? '0 : BW'(cnt_b_r + 1'b1);
      if (sub_rise) begin
        cnt_s_r <= wrap_s ? '0 : SW'(cnt_s_r + 1'b1);
      end
      sub_q_r <= subclock_in;
      tick_r <= tick_sel;
    end
  end
  assign tick_out = tick_r;
endmodule
`default_nettype wire

//--- src/opt_irq_ctrl.sv
// opt_irq_ctrl: sticky interrupt status, write-one-to-clear, with mask
`timescale 1ns/1ps
`default_nettype none
module opt_irq_ctrl #(
  parameter int W = opt_pkg::IRQ_W
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // events and software access
  input wire logic [W-1:0] event_in,
  input wire logic clear_wr_in,
  input wire logic mask_wr_in,
  input wire logic [W-1:0] wdata_in,
  // state
  output logic [W-1:0] status_out,
  output logic [W-1:0] mask_out,
  output logic irq_out
);
  if (W < 1) begin : g_bad_w
    $error("opt_irq_ctrl: width must be at least 1");
  end
  logic [W-1:0] status_r;
  logic [W-1:0] mask_r;
  // set beats a clear landing in the same cycle
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
        status_r[i] <= 1'b0;
      end else if (event_in[i]) begin
        status_r[i] <= 1'b1;
      end else if (clear_wr_in && wdata_in[i]) begin
        status_r[i] <= 1'b0;
      end
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      mask_r <= '0;
    end else if (mask_wr_in) begin
      mask_r <= wdata_in;
    end
  end
  assign status_out = status_r;
  assign mask_out = mask_r;
  assign irq_out = |(status_r & mask_r);
endmodule
`default_nettype wire

//--- src/opt_timer.sv
// opt_timer: 16-bit down-counting one-shot / pulse width modulation timer with apb slave
// Operation
// - one-shot counter decrements once per tick of the selected prescaled source
// - at zero the one-shot reloads the reload value, then halts
// - one-shot trigger while running reloads the counter and restarts
// - one-shot starts on pin trigger, timer overflow or one-shot start flag
// - one-shot stops after the zero reload, or when start flag cleared
// - one-shot raises its interrupt when the count reaches zero
// - pins act as gpio or as trigger input and pulse output
// - timer register reads return a fixed undefined value, never the count
// - timer write while stopped loads both reload register and counter
// - timer write while counting loads reload only, used at next reload
// - modulation counts down as 16-bit or prescaled 8-bit modulator
// - modulation reloads at each pulse rising edge and keeps counting
// - modulation ignores triggers while running
// - 16-bit modulation: high for n ticks within a 65535-tick cycle
// - 8-bit modulation: high n*(m+1) ticks within 255*(m+1) ticks
// - modulation starts on trigger, timer overflow or count start flag
// - modulation stops only when count start flag cleared; pin is pulse output
`timescale 1ns/1ps
`default_nettype none
module opt_timer #(
  parameter int CNT_W = opt_pkg::CNT_W
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // pins and sources
  input wire logic timer_trigger_input_pin_in,
  input wire logic other_timer_overflow_in,
  input wire logic subclock_in,
  output logic timer_pulse_output_pin_out,
  // interrupt
  output logic irq_out
);
  if (CNT_W != 16) begin : g_bad_width
    $error("opt_timer: the 8-bit split needs a 16-bit counter");
  end
  // ***************************************************************************
  // apb decode
  // ***************************************************************************
  logic [opt_pkg::CTRL_W-1:0] ctrl_r;
  logic [15:0] reload_r;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [15:0] cyc_r;
  logic [15:0] cyc_nxt;
  logic [7:0] pre_r;
  logic [7:0] pre_nxt;
  logic out_r;
  logic out_nxt;
  logic pin_q_r;
  logic pin_r;
  logic [31:0] prdata_r;
  logic [31:0] rd_data;
  opt_pkg::opt_state_type state_r;
  opt_pkg::opt_state_type state_nxt;
  logic os_done;
  logic pwm_fall;
  logic tick;
  logic [opt_pkg::IRQ_W-1:0] irq_stat;
  logic [opt_pkg::IRQ_W-1:0] irq_mask;
  wire logic bus_setup = psel_in & ~penable_in;
  wire logic bus_access = psel_in & penable_in;
  wire logic bus_wr = bus_access & pwrite_in;
  wire logic sel_ctrl = paddr_in == opt_pkg::ADDR_CTRL;
  wire logic sel_ostart = paddr_in == opt_pkg::ADDR_OSTART;
  wire logic sel_timer = paddr_in == opt_pkg::ADDR_TIMER;
  wire logic sel_status = paddr_in == opt_pkg::ADDR_STATUS;
  wire logic sel_istat = paddr_in == opt_pkg::ADDR_IRQ_STAT;
  wire logic sel_imask = paddr_in == opt_pkg::ADDR_IRQ_MASK;
  wire logic mapped = sel_ctrl | sel_ostart | sel_timer | sel_status | sel_istat | sel_imask;
  wire logic wr_ctrl = bus_wr & sel_ctrl;
  wire logic wr_timer = bus_wr & sel_timer;
  wire logic wr_istat = bus_wr & sel_istat;
  wire logic wr_imask = bus_wr & sel_imask;
  // ***************************************************************************
  // control fields and triggers
  // ***************************************************************************
  wire logic start_flag = ctrl_r[opt_pkg::CTRL_START_BIT];
  wire logic mode_pwm = ctrl_r[opt_pkg::CTRL_MODE_BIT];
  wire logic pwm8 = ctrl_r[opt_pkg::CTRL_PWM8_BIT];
  wire logic [1:0] clk_sel = ctrl_r[opt_pkg::CTRL_CLK_LSB +: 2];
  wire logic trig_pin_en = ctrl_r[opt_pkg::CTRL_TRIG_PIN_BIT];
  wire logic trig_ovf_en = ctrl_r[opt_pkg::CTRL_TRIG_OVF_BIT];
  wire logic pulse_out_en = ctrl_r[opt_pkg::CTRL_PULSE_OUT_BIT];
  wire logic gpio_out = ctrl_r[opt_pkg::CTRL_GPIO_OUT_BIT];
  wire logic pin_rise = timer_trigger_input_pin_in & ~pin_q_r;
  wire logic ext_trig = (trig_pin_en & pin_rise) | (trig_ovf_en & other_timer_overflow_in);
  wire logic need_trig = trig_pin_en | trig_ovf_en;
  wire logic os_start = bus_wr & sel_ostart & pwdata_in[opt_pkg::OSTART_BIT];
  wire logic os_trig = ext_trig | os_start;
  wire logic running = state_r == opt_pkg::ST_RUN;
  wire logic [15:0] hi_val = pwm8 ? {8'h00, reload_r[15:8]} : reload_r;
  wire logic [7:0] pre_val = reload_r[7:0];
  wire logic [15:0] cyc_last = pwm8 ? opt_pkg::PWM8_LAST : opt_pkg::PWM16_LAST;
  wire logic pre_zero = pre_r == opt_pkg::PRE_ZERO;
  wire logic pwm_tick = tick & (~pwm8 | pre_zero);
  wire logic pin_sel = mode_pwm | pulse_out_en;
  opt_prescaler u_prescaler (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .clk_sel_in(clk_sel),
    .subclock_in(subclock_in),
    .tick_out(tick)
  );
  // ***************************************************************************
  // counter and state
  // ***************************************************************************
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    cyc_nxt = cyc_r;
    pre_nxt = pre_r;
    out_nxt = out_r;
    os_done = 1'b0;
    pwm_fall = 1'b0;
    case (state_r)
      opt_pkg::ST_STOP: begin
        out_nxt = 1'b0;
        if (start_flag) begin
          state_nxt = opt_pkg::ST_WAIT;
        end
      end
      opt_pkg::ST_WAIT: begin
        out_nxt = 1'b0;
        if (!start_flag) begin
          state_nxt = opt_pkg::ST_STOP;
        end else if (!mode_pwm && os_trig) begin
          state_nxt = opt_pkg::ST_RUN;
          cnt_nxt = reload_r;
          out_nxt = 1'b1;
        end else if (mode_pwm && (!need_trig || ext_trig)) begin
          state_nxt = opt_pkg::ST_RUN;
          cnt_nxt = hi_val;
          cyc_nxt = cyc_last;
          pre_nxt = pre_val;
          out_nxt = hi_val != opt_pkg::CNT_ZERO;
        end
      end
      opt_pkg::ST_RUN: begin
        if (!start_flag) begin
          state_nxt = opt_pkg::ST_STOP;
          out_nxt = 1'b0;
        end else if (!mode_pwm) begin
          if (os_trig) begin
            cnt_nxt = reload_r;
            out_nxt = 1'b1;
          end else if (tick) begin
            if (cnt_r <= opt_pkg::CNT_ONE) begin
              cnt_nxt = reload_r;
              out_nxt = 1'b0;
              os_done = 1'b1;
              state_nxt = opt_pkg::ST_WAIT;
            end else begin
              cnt_nxt = 16'(cnt_r - 1'b1);
            end
          end
        end else begin
          // triggers are not looked at here: a running modulator ignores them
          if (tick && pwm8) begin
            pre_nxt = pre_zero ? pre_val : 8'(pre_r - 1'b1);
          end
          if (pwm_tick) begin
            if (cyc_r == opt_pkg::CNT_ZERO) begin
              cyc_nxt = cyc_last;
              cnt_nxt = hi_val;
              out_nxt = hi_val != opt_pkg::CNT_ZERO;
            end else begin
              cyc_nxt = 16'(cyc_r - 1'b1);
              if (cnt_r != opt_pkg::CNT_ZERO) begin
                cnt_nxt = 16'(cnt_r - 1'b1);
                out_nxt = cnt_r != opt_pkg::CNT_ONE;
                pwm_fall = cnt_r == opt_pkg::CNT_ONE;
              end
            end
          end
        end
      end
      default: begin
        state_nxt = opt_pkg::ST_STOP;
        out_nxt = 1'b0;
      end
    endcase
    if (wr_timer && !running) begin
      cnt_nxt = pwdata_in[15:0];
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      state_r <= opt_pkg::ST_STOP;
      cnt_r <= opt_pkg::CNT_ZERO;
      cyc_r <= opt_pkg::CNT_ZERO;
      pre_r <= opt_pkg::PRE_ZERO;
      out_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      cyc_r <= cyc_nxt;
      pre_r <= pre_nxt;
      out_r <= out_nxt;
    end
  end
  // ***************************************************************************
  // registers and pins
  // ***************************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      ctrl_r <= opt_pkg::CTRL_RST;
      reload_r <= opt_pkg::CNT_ZERO;
      pin_q_r <= 1'b0;
      pin_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= pwdata_in[opt_pkg::CTRL_W-1:0];
      end
      if (wr_timer) begin
        reload_r <= pwdata_in[15:0];
      end
      pin_q_r <= timer_trigger_input_pin_in;
      pin_r <= pin_sel ? out_r : gpio_out;
    end
  end
  // ***************************************************************************
  // read path: data captured in the setup cycle, zero wait states
  // ***************************************************************************
  always_comb begin
    rd_data = 32'h0000_0000;
    if (sel_ctrl) begin
      rd_data[opt_pkg::CTRL_W-1:0] = ctrl_r;
    end else if (sel_timer) begin
      rd_data[15:0] = opt_pkg::TIMER_READ_VALUE;
    end else if (sel_status) begin
      rd_data[opt_pkg::STAT_RUN_BIT] = running;
      rd_data[opt_pkg::STAT_OUT_BIT] = out_r;
      rd_data[opt_pkg::STAT_PIN_BIT] = timer_trigger_input_pin_in;
      rd_data[opt_pkg::STAT_WAIT_BIT] = state_r == opt_pkg::ST_WAIT;
    end else if (sel_istat) begin
      rd_data[opt_pkg::IRQ_W-1:0] = irq_stat;
    end else if (sel_imask) begin
      rd_data[opt_pkg::IRQ_W-1:0] = irq_mask;
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      prdata_r <= 32'h0000_0000;
    end else if (bus_setup && !pwrite_in) begin
      prdata_r <= rd_data;
    end
  end
  assign prdata_out = prdata_r;
  assign pready_out = 1'b1;
  assign pslverr_out = bus_access & ~mapped;
  assign timer_pulse_output_pin_out = pin_r;
  opt_irq_ctrl u_irq (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .event_in({pwm_fall, os_done}),
    .clear_wr_in(wr_istat),
    .mask_wr_in(wr_imask),
    .wdata_in(pwdata_in[opt_pkg::IRQ_W-1:0]),
    .status_out(irq_stat),
    .mask_out(irq_mask),
    .irq_out(irq_out)
  );
  // ***************************************************************************
  // checks
  // ***************************************************************************
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  wire logic os_run = running & ~mode_pwm & start_flag;
  wire logic pwm_run = running & mode_pwm & start_flag;
  chk_os_count_down: assert property (
    os_run && tick && !os_trig && cnt_r > opt_pkg::CNT_ONE |=> cnt_r == $past(cnt_r) - 16'h0001)
    else $error("one-shot count did not step down on tick");
  chk_os_halt_reload: assert property (
    os_run && tick && !os_trig && cnt_r <= opt_pkg::CNT_ONE
    |=> state_r == opt_pkg::ST_WAIT && cnt_r == $past(reload_r) && !out_r)
    else $error("one-shot did not reload and halt at zero");
  chk_os_retrigger: assert property (
    os_run && os_trig |=> running && cnt_r == $past(reload_r) && out_r)
    else $error("one-shot retrigger did not restart the count");
  chk_os_launch: assert property (
    state_r == opt_pkg::ST_WAIT && start_flag && !mode_pwm && os_trig |=> running && out_r)
    else $error("one-shot did not start on trigger");
  chk_flag_stop: assert property (
    state_r != opt_pkg::ST_STOP && !start_flag
    |=> state_r == opt_pkg::ST_STOP && !out_r ##1 (!pin_r || !$past(pin_sel)))
    else $error("clearing the start flag did not stop the channel");
  chk_os_irq_set: assert property (
    os_done |=> irq_stat[opt_pkg::IRQ_OS_BIT])
    else $error("one-shot zero did not set its interrupt bit");
  chk_pin_select: assert property (
    !mode_pwm && !pulse_out_en && $stable(ctrl_r) |=> pin_r == $past(gpio_out))
    else $error("gpio level not on output pin");
  chk_timer_read: assert property (
    bus_access && !pwrite_in && sel_timer |-> prdata_out[15:0] == opt_pkg::TIMER_READ_VALUE)
    else $error("timer read returned something other than the fixed value");
  chk_wr_stopped: assert property (
    wr_timer && !running && state_r == opt_pkg::ST_STOP && !start_flag
    |=> cnt_r == $past(pwdata_in[15:0]) && reload_r == cnt_r)
    else $error("stopped write did not load counter and reload");
  chk_wr_running: assert property (
    wr_timer && os_run && !os_trig && cnt_r > opt_pkg::CNT_ONE
    |=> cnt_r == $past(cnt_r) - {15'h0000, $past(tick)}
    && reload_r == $past(pwdata_in[15:0]))
    else $error("running write disturbed the counter");
  chk_pwm_restart: assert property (
    pwm_run && pwm_tick && cyc_r == opt_pkg::CNT_ZERO |=> cnt_r == $past(hi_val) && running)
    else $error("modulator did not reload at cycle start");
  chk_pwm_ignore: assert property (
    pwm_run && ext_trig && !pwm_tick |=> cnt_r == $past(cnt_r) && out_r == $past(out_r))
    else $error("running modulator reacted to a trigger");
  chk_pwm_level: assert property (
    running && mode_pwm |-> out_r == (cnt_r != opt_pkg::CNT_ZERO))
    else $error("modulator output does not follow its count");
  chk_pwm8_prescale: assert property (
    pwm_run && pwm8 && !pre_zero |=> cyc_r == $past(cyc_r) && cnt_r == $past(cnt_r))
    else $error("8-bit modulator stepped without prescaler wrap");
  chk_pwm_launch: assert property (
    state_r == opt_pkg::ST_WAIT && start_flag && mode_pwm && !need_trig |=> running)
    else $error("modulator did not start on start flag");
  chk_pwm_fall_irq: assert property (
    pwm_fall |=> !out_r && irq_stat[opt_pkg::IRQ_PWM_BIT])
    else $error("falling pulse did not raise interrupt");
  cov_os_done: cover property (os_done);
  cov_os_retrig: cover property (os_run && os_trig);
  cov_pwm_fall: cover property (pwm_fall);
  cov_pwm8_cycle: cover property (pwm_run && pwm8 && pwm_tick && cyc_r == opt_pkg::CNT_ZERO);
endmodule
`default_nettype wire

//--- dv/opt_partner.sv
// opt_partner: trigger sources, subclock and pulse-width meter at the timer's pins
`timescale 1ns/1ps
`default_nettype none
module opt_partner (
  // clock
  input wire logic sys_clk_in,
  // requests from the bench and the timer's pulse
  input wire logic pulse_in,
  input wire logic pin_req_in,
  input wire logic ovf_req_in,
  // drive to the timer
  output logic trig_pin_out = 1'b0,
  output logic ovf_out = 1'b0,
  output logic subclk_out = 1'b0,
  // measured high time and period, in clock cycles
  output int hi_out = 0,
  output int per_out = 0
);
  logic p_d = 1'b0;
  logic o_d = 1'b0;
  logic [1:0] sub_cnt = 2'h0;
  int hc = 0;
  int pc = 0;
  always_ff @(posedge sys_clk_in) begin
    p_d <= pulse_in;
    o_d <= ovf_req_in;
    trig_pin_out <= pin_req_in;
    ovf_out <= ovf_req_in & ~o_d; // one-cycle overflow pulse
    sub_cnt <= sub_cnt + 2'h1;
    subclk_out <= sub_cnt[1];
    if (pulse_in & ~p_d) begin
      hc <= 1;
      pc <= 1;
      per_out <= pc;
    end else begin
      pc <= pc + 1;
      hc <= hc + (pulse_in ? 1 : 0);
    end
    if (~pulse_in & p_d) begin
      hi_out <= hc;
    end
  end
endmodule
`default_nettype wire

//--- dv/opt_timer_tb.sv
// opt_timer_tb: apb-driven tests of the one-shot / pwm timer
`timescale 1ns/1ps
`default_nettype none
module opt_timer_tb;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, pin_req = 0, ovf_req = 0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0, rdat, prd;
  logic prdy, perr, trig, ovf, sub, pout, irq, err;
  int miscompares = 0, comparisons = 0, cyc = 0, hi, per;
  int src_per[4] = '{1, opt_pkg::DIV_MAIN_A, opt_pkg::DIV_MAIN_B, opt_pkg::DIV_SUB * 4};
  always #2.5 clk = ~clk;
  opt_timer DUT (.sys_clk_in(clk), .sys_rst_in(rst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
    .pslverr_out(perr), .timer_trigger_input_pin_in(trig), .other_timer_overflow_in(ovf),
    .subclock_in(sub), .timer_pulse_output_pin_out(pout), .irq_out(irq));
  opt_partner model (.sys_clk_in(clk), .pulse_in(pout), .pin_req_in(pin_req),
    .ovf_req_in(ovf_req), .trig_pin_out(trig), .ovf_out(ovf), .subclk_out(sub),
    .hi_out(hi), .per_out(per));
  // ***************************************************************************
  // tasks
  // ***************************************************************************
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // entered just after a rising edge; ends one idle edge later so calls never collide
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk) pen <= 1;
    do @(posedge clk); while (prdy !== 1'b1);
    rdat = prd;
    err = perr;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    chk(nm, rdat, e);
  endtask
  task wait_pin(input logic v, input int lim);
    int i;
    for (i = 0; i < lim && pout !== v; i++) @(posedge clk);
    chk("pulse pin", pout, v);
  endtask
  // the meter updates on the edge after the fall, so wait one more edge
  task pulse_chk(input int lim, input int lo, input int up);
    wait_pin(1, lim);
    wait_pin(0, lim);
    @(posedge clk);
    chk("high width", 32'(hi >= lo && hi <= up), 32'h1);
  endtask
  task done(input string t);
    $display("test %s finished", t);
  endtask
  task give_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      miscompares++;
      give_verdict;
    end
  end
  // ***************************************************************************
  // tests
  // ***************************************************************************
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rd("ctrl reset", opt_pkg::ADDR_CTRL, 32'h0);
    rd("unmapped", 8'h18, 32'h0);
    chk("slverr", err, 32'h1);
    wr(opt_pkg::ADDR_CTRL, 32'h100);
    repeat (2) @(posedge clk);
    chk("gpio pin", pout, 32'h1);
    wr(opt_pkg::ADDR_CTRL, 32'h0);
    wr(opt_pkg::ADDR_TIMER, 32'h3);
    rd("timer read", opt_pkg::ADDR_TIMER, 32'h0);
    done("registers");
    wr(opt_pkg::ADDR_IRQ_MASK, 32'h2);
    wr(opt_pkg::ADDR_CTRL, 32'h81);
    wr(opt_pkg::ADDR_OSTART, 32'h1);
    pulse_chk(20, 3, 3);
    repeat (2) @(posedge clk);
    rd("irq status", opt_pkg::ADDR_IRQ_STAT, 32'h1);
    chk("irq masked", irq, 32'h0);
    rd("status", opt_pkg::ADDR_STATUS, 32'h8);
    wr(opt_pkg::ADDR_IRQ_MASK, 32'h3);
    chk("irq raised", irq, 32'h1);
    wr(opt_pkg::ADDR_IRQ_STAT, 32'h1);
    chk("irq cleared", irq, 32'h0);
    done("oneshot");
    wr(opt_pkg::ADDR_TIMER, 32'h6);
    wr(opt_pkg::ADDR_CTRL, 32'hA1);
    pin_req <= 1;
    pulse_chk(20, 6, 6);
    pin_req <= 0;
    wr(opt_pkg::ADDR_CTRL, 32'hC1);
    ovf_req <= 1;
    wait_pin(1, 20);
    wr(opt_pkg::ADDR_TIMER, 32'h4);
    pulse_chk(20, 6, 6);
    ovf_req <= 0;
    @(posedge clk) ovf_req <= 1;
    pulse_chk(20, 4, 4);
    // retrigger lands a few ticks in, so the width is eight plus those ticks
    wr(opt_pkg::ADDR_TIMER, 32'h8);
    wr(opt_pkg::ADDR_CTRL, 32'h81);
    wr(opt_pkg::ADDR_OSTART, 32'h1);
    wait_pin(1, 20);
    wr(opt_pkg::ADDR_OSTART, 32'h1);
    pulse_chk(40, 9, 15);
    wr(opt_pkg::ADDR_OSTART, 32'h1);
    wait_pin(1, 20);
    wr(opt_pkg::ADDR_CTRL, 32'h80);
    repeat (2) @(posedge clk);
    chk("stopped pin", pout, 32'h0);
    rd("stopped", opt_pkg::ADDR_STATUS, 32'h0);
    done("triggers");
    for (int s = 0; s < 4; s++) begin
      wr(opt_pkg::ADDR_TIMER, 32'h2);
      wr(opt_pkg::ADDR_CTRL, 32'h81 | (s << 3));
      wr(opt_pkg::ADDR_OSTART, 32'h1);
      pulse_chk(600, src_per[s] + 1, 2 * src_per[s]);
    end
    done("sources");
    wr(opt_pkg::ADDR_IRQ_STAT, 32'h3);
    wr(opt_pkg::ADDR_TIMER, 32'h301);
    wr(opt_pkg::ADDR_CTRL, 32'h27);
    pin_req <= 1;
    pulse_chk(20, 6, 6);
    pin_req <= 0;
    repeat (2) @(posedge clk);
    pin_req <= 1;
    pulse_chk(600, 6, 6);
    chk("pwm8 period", per, 32'h1FE);
    rd("pwm irq", opt_pkg::ADDR_IRQ_STAT, 32'h2);
    done("pwm8");
    wr(opt_pkg::ADDR_CTRL, 32'h0);
    wr(opt_pkg::ADDR_TIMER, 32'h5);
    wr(opt_pkg::ADDR_CTRL, 32'h3);
    pulse_chk(20, 5, 5);
    pulse_chk(65600, 5, 5);
    chk("pwm16 period", per, 32'hFFFF);
    wr(opt_pkg::ADDR_CTRL, 32'h0);
    repeat (3) @(posedge clk);
    chk("pwm stopped", pout, 32'h0);
    done("pwm16");
    give_verdict;
  end
endmodule
`default_nettype wire
